//--- design/output_trigger_mode_controller.sv
// What this block does
// - continuous mode drives output always
// - triggered mode starts on trigger, runs till stop
// - sync pulse after sync latency on 10 MHz
// - output after launch latency; sum equals delay
// - synth off adjusts sync, on adjusts launch
// - stop after 0.2us, then 2.5us recovery
// - gated mode outputs only while gate active
// - gated mode uses triggered-mode latencies
// - timed burst runs channel duration per trigger
// - sweep or modulation other than AM: one sequence per trigger
// - source cycles external, manual, internal; internal skipped outside burst
// - manual press triggers; held button gates
// - internal triggers one period apart, one burst
// - delay 0.7us to 100s, all sources
// - external edge chosen by polarity
// - gated level chosen by polarity for the external input; manual gate uses the button level
// - period 10us to 100s, above delay+burst+2.5us
// - period raised when delay or burst grows
// - burst per channel, 0.4us to 100s
// - both channels share source and mode
// - settings shared across triggered modes
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module output_trigger_mode_controller #(
  parameter int unsigned TICK_DIV = trig_mode_pkg::TICK_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig_pin,
  input wire logic manual_btn,
  input wire logic seq_done,
  output logic [1:0] out_en,
  output logic sync_pulse,
  output logic busy
);
  generate
    if (TICK_DIV < 2 || TICK_DIV > 255) begin : g_bad_div
      $error("TICK_DIV out of range");
    end
  endgenerate

  trig_mode_pkg::ctrl_s ctrl_q;
  logic [31:0] delay_q;
  logic [31:0] burst_q [2];
  logic [31:0] period_q;
  trig_mode_pkg::state_e st_q;
  logic [31:0] timer_q;
  logic [31:0] ch_cnt_q [2];
  logic [1:0] ch_on_q;
  logic [31:0] int_cnt_q;
  logic [7:0] div_q;
  logic tick_q;
  logic [2:0] pin_sync_q;
  logic [2:0] btn_sync_q;
  logic pin_lvl_q;
  logic btn_lvl_q;
  logic stop_req_q;
  logic seq_seen_q;
  logic int_trig_q;
  logic [1:0] out_en_q;
  logic sync_pulse_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic busy_q;

  wire logic acc = psel && penable && pready_q;
  wire logic wr = acc && pwrite;
  wire logic addr_ok = paddr inside {trig_mode_pkg::ADDR_CTRL, trig_mode_pkg::ADDR_DELAY,
    trig_mode_pkg::ADDR_BURST0, trig_mode_pkg::ADDR_BURST1, trig_mode_pkg::ADDR_PERIOD,
    trig_mode_pkg::ADDR_STATUS};

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo);
    clamp = (v < lo) ? lo : ((v > trig_mode_pkg::MAX_SETTING_TICKS) ?
      trig_mode_pkg::MAX_SETTING_TICKS : v);
  endfunction

  // apb: no wait state; every bus output comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          trig_mode_pkg::ADDR_CTRL: prdata_q <= {24'h00_0000, ctrl_q};
          trig_mode_pkg::ADDR_DELAY: prdata_q <= delay_q;
          trig_mode_pkg::ADDR_BURST0: prdata_q <= burst_q[0];
          trig_mode_pkg::ADDR_BURST1: prdata_q <= burst_q[1];
          trig_mode_pkg::ADDR_PERIOD: prdata_q <= period_q;
          trig_mode_pkg::ADDR_STATUS: prdata_q <= {24'h00_0000, btn_lvl_q, pin_lvl_q,
            out_en_q, 1'b0, st_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control: one mode and source shared by both channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= trig_mode_pkg::CTRL_RST;
    end else if (ce && wr && paddr == trig_mode_pkg::ADDR_CTRL) begin
      logic [1:0] src;
      logic is_burst;
      src = pwdata[trig_mode_pkg::CTRL_SRC_LSB +: 2];
      is_burst = pwdata[trig_mode_pkg::CTRL_MODE_LSB +: 2] == 2'(trig_mode_pkg::MODE_BURST);
      if (pwdata[trig_mode_pkg::CTRL_STEP_BIT]) begin
        src = 2'(ctrl_q.source) + 2'd1;
      end
      if (src == 2'd3 || (src == 2'(trig_mode_pkg::SRC_INT) && !is_burst)) begin
        src = 2'(trig_mode_pkg::SRC_EXT);
      end
      ctrl_q.mode <= trig_mode_pkg::mode_e'(pwdata[trig_mode_pkg::CTRL_MODE_LSB +: 2]);
      ctrl_q.source <= trig_mode_pkg::source_e'(src);
      ctrl_q.neg_pol <= pwdata[trig_mode_pkg::CTRL_POL_BIT];
      ctrl_q.synth_on <= pwdata[trig_mode_pkg::CTRL_SYNTH_BIT];
      ctrl_q.seq_en <= pwdata[trig_mode_pkg::CTRL_SEQ_BIT];
      ctrl_q.am_excepted <= pwdata[trig_mode_pkg::CTRL_AMX_BIT];
    end
  end

  // timing settings in 10 MHz ticks, clamped to their ranges
  wire logic [31:0] max_burst = (burst_q[0] > burst_q[1]) ? burst_q[0] : burst_q[1];
  wire logic [31:0] period_need = delay_q + max_burst + 32'(trig_mode_pkg::RECOVER_TICKS) + 32'd1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_q <= trig_mode_pkg::DELAY_RST;
      burst_q[0] <= trig_mode_pkg::BURST_RST;
      burst_q[1] <= trig_mode_pkg::BURST_RST;
    end else if (ce && wr) begin
      if (paddr == trig_mode_pkg::ADDR_DELAY) begin
        delay_q <= clamp(pwdata, 32'(trig_mode_pkg::DELAY_MIN_TICKS));
      end
      if (paddr == trig_mode_pkg::ADDR_BURST0) begin
        burst_q[0] <= clamp(pwdata, 32'(trig_mode_pkg::BURST_MIN_TICKS));
      end
      if (paddr == trig_mode_pkg::ADDR_BURST1) begin
        burst_q[1] <= clamp(pwdata, 32'(trig_mode_pkg::BURST_MIN_TICKS));
      end
    end
  end

  // a too short period is lifted to the least legal one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_q <= trig_mode_pkg::PERIOD_RST;
    end else if (ce) begin
      if (period_q < period_need) begin
        period_q <= period_need;
      end else if (wr && paddr == trig_mode_pkg::ADDR_PERIOD) begin
        period_q <= clamp(pwdata, 32'(trig_mode_pkg::PERIOD_MIN_TICKS));
      end
    end
  end

  // pins: three flops, a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_q <= 3'h0;
      btn_sync_q <= 3'h0;
      pin_lvl_q <= 1'b0;
      btn_lvl_q <= 1'b0;
    end else if (ce) begin
      pin_sync_q <= {pin_sync_q[1:0], trig_pin};
      btn_sync_q <= {btn_sync_q[1:0], manual_btn};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        pin_lvl_q <= pin_sync_q[2];
      end
      if (btn_sync_q[1] == btn_sync_q[2]) begin
        btn_lvl_q <= btn_sync_q[2];
      end
    end
  end

  wire logic pin_new = (pin_sync_q[1] == pin_sync_q[2]) && (pin_sync_q[2] != pin_lvl_q);
  wire logic btn_new = (btn_sync_q[1] == btn_sync_q[2]) && (btn_sync_q[2] != btn_lvl_q);
  // chosen edge of the external input
  wire logic ext_edge = pin_new && (pin_sync_q[2] != ctrl_q.neg_pol);
  wire logic gate_lvl = (ctrl_q.source == trig_mode_pkg::SRC_MAN) ? btn_lvl_q :
    (pin_lvl_q != ctrl_q.neg_pol);
  wire logic trig_evt = (ctrl_q.source == trig_mode_pkg::SRC_EXT) ? ext_edge :
    (ctrl_q.source == trig_mode_pkg::SRC_MAN) ? (btn_new && btn_sync_q[2]) :
    int_trig_q;
  wire logic is_gate = ctrl_q.mode == trig_mode_pkg::MODE_GATE;
  wire logic use_seq = ctrl_q.seq_en && !ctrl_q.am_excepted;
  wire logic [31:0] sync_ticks = ctrl_q.synth_on ? 32'(trig_mode_pkg::SYNC_FIX_TICKS) :
    delay_q - 32'(trig_mode_pkg::LAUNCH_FIX_TICKS);
  wire logic [31:0] launch_ticks = ctrl_q.synth_on ?
    delay_q - 32'(trig_mode_pkg::SYNC_FIX_TICKS) : 32'(trig_mode_pkg::LAUNCH_FIX_TICKS);

  // 10 MHz tick: every latency is counted on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= div_q == 8'(TICK_DIV - 1);
      div_q <= (div_q == 8'(TICK_DIV - 1)) ? 8'h00 : div_q + 8'h01;
    end
  end

  // internal trigger: one pulse per period, only in burst mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_cnt_q <= 32'h0000_0000;
      int_trig_q <= 1'b0;
    end else if (ce) begin
      int_trig_q <= 1'b0;
      if (ctrl_q.source != trig_mode_pkg::SRC_INT) begin
        int_cnt_q <= 32'h0000_0000;
      end else if (tick_q) begin
        int_trig_q <= int_cnt_q == 32'h0000_0000;
        int_cnt_q <= (int_cnt_q >= period_q - 32'd1) ? 32'h0000_0000 : int_cnt_q + 32'd1;
      end
    end
  end

  // a stop request acts at once; a sequence-end request waits for the next tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_req_q <= 1'b0;
      seq_seen_q <= 1'b0;
    end else if (ce) begin
      if (wr && paddr == trig_mode_pkg::ADDR_CTRL && pwdata[trig_mode_pkg::CTRL_STOP_BIT]) begin
        stop_req_q <= 1'b1;
      end else if (st_q != trig_mode_pkg::ST_ACTIVE) begin
        stop_req_q <= 1'b0;
      end
      if (seq_done && st_q == trig_mode_pkg::ST_ACTIVE) begin
        seq_seen_q <= 1'b1;
      end else if (st_q != trig_mode_pkg::ST_ACTIVE) begin
        seq_seen_q <= 1'b0;
      end
    end
  end

  // start/stop sequencer, the same for both channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= trig_mode_pkg::ST_IDLE;
      timer_q <= 32'h0000_0000;
      sync_pulse_q <= 1'b0;
    end else if (ce) begin
      sync_pulse_q <= 1'b0;
      case (st_q)
        trig_mode_pkg::ST_IDLE: begin
          // only idle takes a trigger; busy and recovery ignore them
          if (ctrl_q.mode != trig_mode_pkg::MODE_CONT && (is_gate ? gate_lvl : trig_evt)) begin
            st_q <= trig_mode_pkg::ST_SYNC;
            timer_q <= sync_ticks;
          end
        end
        trig_mode_pkg::ST_SYNC: begin
          if (is_gate && !gate_lvl) begin
            st_q <= trig_mode_pkg::ST_STOP;
            timer_q <= 32'(trig_mode_pkg::STOP_LAT_TICKS);
          end else if (tick_q) begin
            if (timer_q <= 32'd1) begin
              st_q <= trig_mode_pkg::ST_LAUNCH;
              sync_pulse_q <= 1'b1;
              timer_q <= launch_ticks;
            end else begin
              timer_q <= timer_q - 32'd1;
            end
          end
        end
        trig_mode_pkg::ST_LAUNCH: begin
          if (is_gate && !gate_lvl) begin
            st_q <= trig_mode_pkg::ST_STOP;
            timer_q <= 32'(trig_mode_pkg::STOP_LAT_TICKS);
          end else if (tick_q) begin
            if (timer_q <= 32'd1) begin
              st_q <= trig_mode_pkg::ST_ACTIVE;
            end else begin
              timer_q <= timer_q - 32'd1;
            end
          end
        end
        trig_mode_pkg::ST_ACTIVE: begin
          if (ctrl_q.mode == trig_mode_pkg::MODE_CONT) begin
            st_q <= trig_mode_pkg::ST_IDLE;
          end else if ((is_gate && !gate_lvl) || stop_req_q) begin
            st_q <= trig_mode_pkg::ST_STOP;
            timer_q <= 32'(trig_mode_pkg::STOP_LAT_TICKS);
          end else if (ctrl_q.mode == trig_mode_pkg::MODE_BURST && tick_q &&
                       (use_seq ? seq_seen_q : ch_on_q == 2'b00)) begin
            st_q <= trig_mode_pkg::ST_RECOVER;
            timer_q <= 32'(trig_mode_pkg::RECOVER_TICKS);
          end
        end
        trig_mode_pkg::ST_STOP: begin
          if (tick_q) begin
            if (timer_q <= 32'd1) begin
              st_q <= trig_mode_pkg::ST_RECOVER;
              timer_q <= 32'(trig_mode_pkg::RECOVER_TICKS);
            end else begin
              timer_q <= timer_q - 32'd1;
            end
          end
        end
        trig_mode_pkg::ST_RECOVER: begin
          if (tick_q) begin
            if (timer_q <= 32'd1) begin
              st_q <= trig_mode_pkg::ST_IDLE;
            end else begin
              timer_q <= timer_q - 32'd1;
            end
          end
        end
        default: st_q <= trig_mode_pkg::ST_IDLE;
      endcase
    end
  end

  // per-channel burst timers, ignored while a sequence sets the length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_cnt_q[0] <= 32'h0000_0000;
      ch_cnt_q[1] <= 32'h0000_0000;
      ch_on_q <= 2'b00;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (st_q != trig_mode_pkg::ST_ACTIVE) begin
          ch_cnt_q[i] <= 32'h0000_0000;
          ch_on_q[i] <= 1'b1;
        end else if (tick_q && ch_on_q[i]) begin
          ch_cnt_q[i] <= ch_cnt_q[i] + 32'd1;
          if (ch_cnt_q[i] + 32'd1 >= burst_q[i] &&
              ctrl_q.mode == trig_mode_pkg::MODE_BURST && !use_seq) begin
            ch_on_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  // output enables; continuous mode never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_en_q <= 2'b00;
    end else if (ce) begin
      if (ctrl_q.mode == trig_mode_pkg::MODE_CONT) begin
        out_en_q <= 2'b11;
      end else if (st_q == trig_mode_pkg::ST_STOP) begin
        out_en_q <= out_en_q;
      end else if (st_q == trig_mode_pkg::ST_ACTIVE) begin
        out_en_q <= use_seq ? 2'b11 : ch_on_q;
      end else begin
        out_en_q <= 2'b00;
      end
    end
  end

  // busy from a flop, one cycle behind the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (ce) begin
      busy_q <= st_q != trig_mode_pkg::ST_IDLE;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign out_en = out_en_q;
  assign sync_pulse = sync_pulse_q;
  assign busy = busy_q;

  cont_output_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ctrl_q.mode == trig_mode_pkg::MODE_CONT |=> out_en_q == 2'b11)
    else $error("continuous mode lost output");
  sync_then_launch_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sync_pulse_q) |-> st_q == trig_mode_pkg::ST_LAUNCH &&
      $past(st_q) == trig_mode_pkg::ST_SYNC)
    else $error("sync pulse out of place");
  delay_split_a: assert property (@(posedge pclk) disable iff (!presetn)
    sync_ticks + launch_ticks == delay_q)
    else $error("delay split does not sum");
  synth_split_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q.synth_on |-> sync_ticks == 32'(trig_mode_pkg::SYNC_FIX_TICKS))
    else $error("synth on changed sync latency");
  recover_len_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    $rose(st_q == trig_mode_pkg::ST_RECOVER) |->
      ##249 st_q == trig_mode_pkg::ST_RECOVER ##1 st_q == trig_mode_pkg::ST_IDLE)
    else $error("recovery not 2.5 us");
  gate_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && is_gate && st_q == trig_mode_pkg::ST_ACTIVE && !gate_lvl
      |=> st_q == trig_mode_pkg::ST_STOP)
    else $error("gate end did not stop");
  busy_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == trig_mode_pkg::ST_RECOVER && !tick_q |=> st_q == trig_mode_pkg::ST_RECOVER)
    else $error("recovery left early");
  period_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && period_q < period_need |=> period_q == $past(period_need))
    else $error("period not raised");
  int_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q.source == trig_mode_pkg::SRC_INT |-> ctrl_q.mode == trig_mode_pkg::MODE_BURST)
    else $error("internal source outside burst");
  launch_cov: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(st_q == trig_mode_pkg::ST_ACTIVE));
  burst_cov: cover property (@(posedge pclk) disable iff (!presetn)
    ctrl_q.mode == trig_mode_pkg::MODE_BURST && $rose(st_q == trig_mode_pkg::ST_RECOVER));
  stop_cov: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(st_q == trig_mode_pkg::ST_STOP));
endmodule // output_trigger_mode_controller

//--- design/trig_mode_pkg.sv
package trig_mode_pkg;
  // base clock and the internal 10 MHz tick
  localparam int unsigned PCLK_NS = 10;
  localparam int unsigned TICK_NS = 100;
  localparam int unsigned TICK_DIV = TICK_NS / PCLK_NS;
  // times in ns, counts in 10 MHz ticks (least times rounded up)
  localparam int unsigned STOP_LAT_NS = 200;
  localparam int unsigned STOP_LAT_TICKS = (STOP_LAT_NS + TICK_NS - 1) / TICK_NS;
  localparam int unsigned RECOVER_NS = 2500;
  localparam int unsigned RECOVER_TICKS = (RECOVER_NS + TICK_NS - 1) / TICK_NS;
  localparam int unsigned DELAY_MIN_NS = 700;
  localparam int unsigned DELAY_MIN_TICKS = (DELAY_MIN_NS + TICK_NS - 1) / TICK_NS;
  localparam int unsigned BURST_MIN_NS = 400;
  localparam int unsigned BURST_MIN_TICKS = (BURST_MIN_NS + TICK_NS - 1) / TICK_NS;
  localparam int unsigned PERIOD_MIN_NS = 10000;
  localparam int unsigned PERIOD_MIN_TICKS = (PERIOD_MIN_NS + TICK_NS - 1) / TICK_NS;
  // 100 s in ticks
  localparam logic [31:0] MAX_SETTING_TICKS = 32'h3B9A_CA00;
  // fixed part of the delay split
  localparam int unsigned SYNC_FIX_TICKS = 3;
  localparam int unsigned LAUNCH_FIX_TICKS = DELAY_MIN_TICKS - SYNC_FIX_TICKS;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DELAY = 8'h04;
  localparam logic [7:0] ADDR_BURST0 = 8'h08;
  localparam logic [7:0] ADDR_BURST1 = 8'h0C;
  localparam logic [7:0] ADDR_PERIOD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // control field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_SRC_LSB = 2;
  localparam int unsigned CTRL_POL_BIT = 4;
  localparam int unsigned CTRL_SYNTH_BIT = 5;
  localparam int unsigned CTRL_SEQ_BIT = 6;
  localparam int unsigned CTRL_AMX_BIT = 7;
  localparam int unsigned CTRL_STOP_BIT = 8;
  localparam int unsigned CTRL_STEP_BIT = 9;

  // reset values
  localparam logic [31:0] DELAY_RST = 32'h0000_0007;
  localparam logic [31:0] BURST_RST = 32'h0000_03E8;
  localparam logic [31:0] PERIOD_RST = 32'h0000_2710;

  typedef enum logic [1:0] {MODE_CONT, MODE_TRIG, MODE_GATE, MODE_BURST} mode_e;
  typedef enum logic [1:0] {SRC_EXT, SRC_MAN, SRC_INT} source_e;
  typedef enum logic [2:0] {ST_IDLE, ST_SYNC, ST_LAUNCH, ST_ACTIVE, ST_STOP, ST_RECOVER} state_e;

  typedef struct packed {
    logic am_excepted;
    logic seq_en;
    logic synth_on;
    logic neg_pol;
    source_e source;
    mode_e mode;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{
    am_excepted: 1'b0, seq_en: 1'b0, synth_on: 1'b0, neg_pol: 1'b0,
    source: SRC_EXT, mode: MODE_CONT};
endpackage

//--- bench/trig_src_model.sv
`timescale 1ns/1ps
module trig_src_model (
  input wire logic pclk,
  output logic trig_pin,
  output logic manual_btn
);
  initial begin
    trig_pin = 1'b0;
    manual_btn = 1'b0;
  end
  // 5 quiet cycles before any change keeps the line at or below 10 MHz
  task automatic set_pin(input logic v);
    repeat (5) @(posedge pclk);
    trig_pin <= v;
  endtask
  task automatic set_btn(input logic v);
    repeat (5) @(posedge pclk);
    manual_btn <= v;
  endtask
endmodule // trig_src_model

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, seq_done, pready, pslverr, err;
  logic trig_pin, manual_btn, sync_pulse, busy, ce;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] out_en;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  int n, t0;

  output_trigger_mode_controller #(.TICK_DIV(trig_mode_pkg::TICK_DIV)) dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_pin(trig_pin), .manual_btn(manual_btn), .seq_done(seq_done),
    .out_en(out_en), .sync_pulse(sync_pulse), .busy(busy));
  trig_src_model src_u (.pclk(pclk), .trig_pin(trig_pin), .manual_btn(manual_btn));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic wrap_up;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_in(input string nm, input int lo, input int hi, input int v);
    checked++;
    if (v < lo || v > hi) begin
      mismatches++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask

  // request held until pready seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  // sel 0 out_en, 1 busy, 2 sync_pulse
  task automatic wt(input int sel, input logic [1:0] e, input int lim);
    logic [1:0] g;
    n = 0;
    forever begin
      @(negedge pclk);
      g = (sel == 0) ? out_en : (sel == 1) ? {1'b0, busy} : {1'b0, sync_pulse};
      n++;
      if (g === e || n >= lim) break;
    end
  endtask

  task automatic t_reset;
    repeat (2) @(negedge pclk);
    chk("out_en cont", 32'h0000_0003, {30'h0, out_en});
    rdchk("ctrl", trig_mode_pkg::ADDR_CTRL, 32'h0000_0000);
    rdchk("delay", trig_mode_pkg::ADDR_DELAY, trig_mode_pkg::DELAY_RST);
    rdchk("burst0", trig_mode_pkg::ADDR_BURST0, trig_mode_pkg::BURST_RST);
    rdchk("burst1", trig_mode_pkg::ADDR_BURST1, trig_mode_pkg::BURST_RST);
    rdchk("period", trig_mode_pkg::ADDR_PERIOD, trig_mode_pkg::PERIOD_RST);
    rdchk("unmapped data", 8'h18, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    $display("test reset done");
  endtask

  // synth off: launch fixed 4 ticks; synth on: sync fixed 3 ticks
  task automatic t_trig;
    int s, l;
    apb(1'b1, trig_mode_pkg::ADDR_DELAY, 32'h0000_000C);
    for (int i = 0; i < 2; i++) begin
      s = (i == 0) ? 8 : 3;
      l = 12 - s;
      apb(1'b1, trig_mode_pkg::ADDR_CTRL, 32'h0000_0001 | (i << 5));
      repeat (20) @(negedge pclk);
      chk("idle out_en", 32'h0000_0000, {30'h0, out_en});
      src_u.set_pin(1'b1);
      wt(2, 2'b01, 300);
      chk_in("sync lat", s * 10 - 4, s * 10 + 5, n);
      wt(0, 2'b11, 300);
      chk_in("launch lat", l * 10 - 3, l * 10 + 5, n);
      src_u.set_pin(1'b0);
      src_u.set_pin(1'b1);
      repeat (100) @(negedge pclk);
      chk("retrig active", 32'h0000_0003, {30'h0, out_en});
      rdchk("status", trig_mode_pkg::ADDR_STATUS, 32'h0000_0073);
      apb(1'b1, trig_mode_pkg::ADDR_CTRL, 32'h0000_0101 | (i << 5));
      wt(0, 2'b00, 60);
      chk_in("stop lat", 14, 23, n);
      t0 = cyc;
      src_u.set_pin(1'b0);
      src_u.set_pin(1'b1);
      wt(1, 2'b00, 400);
      chk_in("recovery", 245, 256, cyc - t0);
      repeat (150) @(negedge pclk);
      chk("trig in recovery", 32'h0000_0000, {30'h0, out_en});
      src_u.set_pin(1'b0);
    end
    $display("test triggered done");
  endtask

  task automatic t_gate;
    // pin raised in continuous mode so no run starts before the gate test
    apb(1'b1, trig_mode_pkg::ADDR_CTRL, 32'h0000_0010);
    src_u.set_pin(1'b1);
    repeat (2) @(negedge pclk);
    apb(1'b1, trig_mode_pkg::ADDR_CTRL, 32'h0000_0012);
    repeat (200) @(negedge pclk);
    chk("gate inactive", 32'h0000_0000, {30'h0, out_en});
    src_u.set_pin(1'b0);
    wt(0, 2'b11, 300);
    chk_in("gate start", 118, 127, n);
    src_u.set_pin(1'b1);
    wt(0, 2'b00, 60);
    chk_in("gate stop", 16, 36, n);
    wt(1, 2'b00, 400);
    apb(1'b1, trig_mode_pkg::ADDR_CTRL, 32'h0000_0006);
    src_u.set_btn(1'b1);
    wt(0, 2'b11, 300);
    chk("held button", 32'h0000_0003, {30'h0, out_en});
    src_u.set_btn(1'b0);
    wt(0, 2'b00, 60);
    chk("released button", 32'h0000_0000, {30'h0, out_en});
    wt(1, 2'b00, 400);
    apb(1'b1, trig_mode_pkg::ADDR_CTRL, 32'h0000_0005);
    src_u.set_btn(1'b1);
    src_u.set_btn(1'b0);
    wt(0, 2'b11, 300);
    repeat (50) @(negedge pclk);
    chk("manual trig", 32'h0000_0003, {30'h0, out_en});
    apb(1'b1, trig_mode_pkg::ADDR_CTRL, 32'h0000_0105);
    wt(1, 2'b00, 500);
    $display("test gate done");
  endtask

  task automatic t_burst;
    apb(1'b1, trig_mode_pkg::ADDR_DELAY, 32'h0000_0007);
    apb(1'b1, trig_mode_pkg::ADDR_BURST0, 32'h0000_0004);
    apb(1'b1, trig_mode_pkg::ADDR_BURST1, 32'h0000_0008);
    apb(1'b1, trig_mode_pkg::ADDR_PERIOD, 32'h0000_0096);
    apb(1'b1, trig_mode_pkg::ADDR_CTRL, 32'h0000_000B);
    wt(0, 2'b11, 2000);
    t0 = cyc;
    wt(0, 2'b10, 100);
    chk_in("burst first", 38, 42, cyc - t0);
    wt(0, 2'b00, 100);
    chk_in("burst second", 78, 82, cyc - t0);
    wt(0, 2'b11, 2000);
    chk_in("int period", 1490, 1510, cyc - t0);
    apb(1'b1, trig_mode_pkg::ADDR_DELAY, 32'h0000_00C8);
    repeat (3) @(negedge pclk);
    rdchk("period raised", trig_mode_pkg::ADDR_PERIOD, 32'h0000_00EA);
    apb(1'b1, trig_mode_pkg::ADDR_DELAY, 32'h0000_0007);
    apb(1'b1, trig_mode_pkg::ADDR_CTRL, 32'h0000_004B);
    wt(0, 2'b11, 3000);
    repeat (100) @(negedge pclk);
    chk("seq ignores time", 32'h0000_0003, {30'h0, out_en});
    @(posedge pclk);
    seq_done <= 1'b1;
    @(posedge pclk);
    seq_done <= 1'b0;
    wt(0, 2'b00, 30);
    chk("seq end", 32'h0000_0000, {30'h0, out_en});
    apb(1'b1, trig_mode_pkg::ADDR_CTRL, 32'h0000_00CB);
    wt(0, 2'b11, 3000);
    t0 = cyc;
    wt(0, 2'b10, 100);
    chk_in("am burst", 38, 42, cyc - t0);
    // low clock enable holds the second channel's burst for 50 cycles
    @(posedge pclk);
    ce <= 1'b0;
    repeat (50) @(posedge pclk);
    ce <= 1'b1;
    @(negedge pclk);
    chk("frozen burst", 32'h0000_0002, {30'h0, out_en});
    wt(0, 2'b00, 100);
    chk_in("resumed burst", 128, 132, cyc - t0);
    $display("test burst done");
  endtask

  task automatic t_src;
    logic [31:0] cur;
    // burst test leaves the internal source selected
    cur = 2;
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, trig_mode_pkg::ADDR_CTRL, 32'h0000_0203 | (cur << 2));
      cur = (cur + 1) % 3;
      rdchk("src step", trig_mode_pkg::ADDR_CTRL, 32'h0000_0003 | (cur << 2));
    end
    apb(1'b1, trig_mode_pkg::ADDR_CTRL, 32'h0000_0009);
    rdchk("int not burst", trig_mode_pkg::ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, trig_mode_pkg::ADDR_CTRL, 32'h0000_0000);
    repeat (5) @(negedge pclk);
    chk("cont again", 32'h0000_0003, {30'h0, out_en});
    $display("test source done");
  endtask

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    seq_done = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_trig();
    t_gate();
    t_burst();
    t_src();
    wrap_up();
  end
endmodule // tb
